// ---- aic_consts.vh ----
// Constants for the activity indicator control block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef AIC_CONSTS_VH
`define AIC_CONSTS_VH

// Register indices; byte address is four times the index
`define AIC_BSR_INDEX 12'h001
`define AIC_CFG_INDEX 12'h450
`define AIC_STS_INDEX 12'h45f

// indicator_config fields
`define AIC_CFG_RESET 16'h2610
`define AIC_CFG_WMASK 16'h7fff
`define AIC_BYPASS_BIT 14
`define AIC_RATE_HI 13
`define AIC_RATE_LO 12
`define AIC_SRC2_LO 8
`define AIC_SRC1_LO 4
`define AIC_SRC0_LO 0

// Basic status fields
`define AIC_BSR_LINK_BIT 2
`define AIC_BSR_LOST_BIT 1

// Source codes
`define AIC_SRC_LINK 4'h0
`define AIC_SRC_LINK_TRX 4'h1
`define AIC_SRC_LINK_TX 4'h2
`define AIC_SRC_LINK_RX 4'h3
`define AIC_SRC_MASTER 4'h4
`define AIC_SRC_SLAVE 4'h5
`define AIC_SRC_ACT 4'h6
`define AIC_SRC_LOST 4'h9
`define AIC_SRC_PRBS 4'ha
`define AIC_SRC_MIIERR 4'hb

// Timing
`define AIC_CLK_HZ 10000000
`define AIC_BLINK0_MS 50
`define AIC_BLINK1_MS 100
`define AIC_BLINK2_MS 200
`define AIC_BLINK3_MS 500
// Half a blink period in clock cycles
`define AIC_HALF_CYC(ms) ((ms) * (`AIC_CLK_HZ / 1000) / 2)

`endif

// ---- aic_stretch.v ----
// Pulse stretcher for one event line of the indicator block.
// Assumes a single clock, event pulses synchronous to it.
`timescale 1ns/1ns
`default_nettype none

module aic_stretch #(
   parameter CW = 24
) (
   input wire clk, // Core clock
   input wire rst_n, // Async reset, active low
   input wire ce, // Clock enable
   input wire ev, // Raw event level or pulse
   input wire bypass, // 1: follow raw event
   input wire [CW-1:0] len, // Stretch length in cycles
   output reg q // Stretched event
);
   reg [CW-1:0] cnt;

   // Reload on every event, then hold for len cycles
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= {CW{1'b0}};
         q <= 1'b0;
      end else if (ce) begin
         if (bypass) begin
            cnt <= {CW{1'b0}};
            q <= ev;
         end else if (ev) begin
            cnt <= len;
            q <= 1'b1;
         end else if (cnt != {CW{1'b0}}) begin
            cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
            q <= (cnt != {{(CW-1){1'b0}}, 1'b1});
         end else begin
            q <= 1'b0;
         end
      end
   end
endmodule // aic_stretch

`default_nettype wire

// ---- aic_top.v ----
// Activity indicator control: three indicator outputs with per-output source selection.
// Assumes an AHB-Lite master on the core clock; status inputs synchronous to clk.
//
// Notes on behaviour
// - Stretch bypass set: indicators follow raw activity and error events, no stretching.
// - Blink select 0..3 gives 20, 10, 5, 2 Hz; reset selects 5 Hz.
// - Codes 0..3 show link up; 1..3 blink on any, transmit, receive activity.
// - Code 4 lights on link up as master; code 5 on link up as slave.
// - Code 6 shows combined transmit and receive activity, stretched unless bypassed.
// - Code 9 lights on link loss; held until basic status register read.
// - Code 10 inverts the indicator on each pseudo-random test error.
// - Code 11 shows interface transmit or receive errors, stretched unless bypassed.
`timescale 1ns/1ns
`default_nettype none
`include "aic_consts.vh"

// Timing overview
// Bus: zero wait states; read data registered at the address edge.
// A write lands at the edge that ends its data phase.
// Indicators: the source mux feeds one output register per pin,
// so a plain source shows on its pin one edge after it settles.
// Stretched sources add one more edge of latency.
// The blink counter runs free; all blinking indicators share one phase,
// which keeps several lamps in step at the cost of a ragged first blink.
// Clock enable low freezes every register, bus answer included.

module aic_top #(
   parameter CW = 24,
   parameter [23:0] HALF0 = `AIC_HALF_CYC(`AIC_BLINK0_MS),
   parameter [23:0] HALF1 = `AIC_HALF_CYC(`AIC_BLINK1_MS),
   parameter [23:0] HALF2 = `AIC_HALF_CYC(`AIC_BLINK2_MS),
   parameter [23:0] HALF3 = `AIC_HALF_CYC(`AIC_BLINK3_MS)
) (
   input wire clk, // Core clock, 10 MHz
   input wire rst_n, // Async reset, active low
   input wire ce, // Clock enable, freezes all state when low
   input wire hsel, // AHB slave select
   input wire [31:0] haddr, // AHB address
   input wire [1:0] htrans, // AHB transfer type
   input wire hwrite, // AHB write
   input wire [2:0] hsize, // AHB size, word only
   input wire [31:0] hwdata, // AHB write data
   input wire hready, // AHB bus ready
   output reg hreadyout, // AHB slave ready
   output reg hresp, // AHB response, always OKAY
   output reg [31:0] hrdata, // AHB read data
   input wire link_up, // Link established level
   input wire master_role, // 1: master role, 0: slave role
   input wire tx_act, // Transmit activity pulse
   input wire rx_act, // Receive activity pulse
   input wire prbs_err, // Test checker error pulse
   input wire mii_tx_err, // Interface transmit error
   input wire mii_rx_err, // Interface receive error
   output reg led_0, // Indicator 0, active high
   output reg led_1, // Indicator 1, active high
   output reg led_2 // Indicator 2, active high
);
   // Register and latch state
   reg [15:0] indicator_config;
   reg link_lost;
   reg link_up_q;
   reg prbs_tog;
   reg blink_phase;
   reg [CW-1:0] blink_cnt;
   reg [CW-1:0] half_len;
   wire [CW-1:0] blink_next;
   localparam [CW-1:0] cnt_one = {{(CW-1){1'b0}}, 1'b1};

   // Bus pipeline and read path
   reg ap_write;
   reg [11:0] ap_index;
   reg [31:0] next_rdata;
   wire ap_take;
   wire addr_in_map;
   wire [11:0] req_index;
   wire bsr_read;

   // Configuration fields
   wire bypass;
   wire [1:0] rate;
   wire [11:0] src_all;

   // Event paths and indicator terms
   wire link_fall;
   wire act_any_s;
   wire act_tx_s;
   wire act_rx_s;
   wire err_s;
   wire trx_blink;
   wire tx_blink;
   wire rx_blink;
   wire [3:0] stretch_ev;
   wire [3:0] stretch_q;
   wire [2:0] led_val;

   // Field slices of the configuration word
   assign bypass = indicator_config[`AIC_BYPASS_BIT];
   assign rate = indicator_config[`AIC_RATE_HI:`AIC_RATE_LO];
   assign src_all = indicator_config[11:0];

   // Address phase decode; index is word address
   // Upper address bits must be zero, so aliases above the map read zero
   assign ap_take = hsel & htrans[1] & hready;
   assign addr_in_map = (haddr[31:14] == 18'h00000);
   assign req_index = haddr[13:2];
   assign bsr_read = ap_take & ~hwrite & addr_in_map & (req_index == `AIC_BSR_INDEX);

   // Register the address phase for the write data phase
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_write <= 1'b0;
         ap_index <= 12'h000;
      end else if (ce) begin
         if (hready) begin
            ap_write <= ap_take & hwrite & addr_in_map;
            ap_index <= req_index;
         end
      end
   end

   // Read mux, sampled at address phase so data stands in the data phase
   // Reads of unmapped words return zero, never a stale value
   always @* begin
      next_rdata = 32'h00000000;
      if (addr_in_map) begin
         case (req_index)
            `AIC_CFG_INDEX: next_rdata = {16'h0000, indicator_config};
            `AIC_BSR_INDEX: begin
               next_rdata[`AIC_BSR_LINK_BIT] = link_up;
               next_rdata[`AIC_BSR_LOST_BIT] = link_lost;
            end
            `AIC_STS_INDEX: begin
               next_rdata[0] = led_0;
               next_rdata[1] = led_1;
               next_rdata[2] = led_2; // Bit 3 stays zero
               next_rdata[4] = act_any_s;
               next_rdata[5] = err_s;
               next_rdata[6] = blink_phase;
               next_rdata[7] = prbs_tog;
            end
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // Bus answer: zero wait states, always OKAY; unmapped reads return zero
   // hrdata holds until the next read, so a late look still sees it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (ap_take & ~hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end

   // Configuration register; reserved bit 15 stays zero
   // Write mask drops bit 15 so software cannot set a reserved bit
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         indicator_config <= `AIC_CFG_RESET;
      end else if (ce) begin
         if (ap_write && ap_index == `AIC_CFG_INDEX) begin
            indicator_config <= hwdata[15:0] & `AIC_CFG_WMASK;
         end
      end
   end

   // Loss is a falling edge of link_up seen while running
   assign link_fall = link_up_q & ~link_up;

   // Link-lost latch; a new loss in the clearing cycle wins over the read
   // Reading the basic status word returns the value before the clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link_up_q <= 1'b0;
         link_lost <= 1'b0;
      end else if (ce) begin
         link_up_q <= link_up;
         if (link_fall) begin
            link_lost <= 1'b1;
         end else if (bsr_read) begin
            link_lost <= 1'b0;
         end
      end
   end

   // Toggle state for test checker errors
   // A level held for several cycles toggles once per cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prbs_tog <= 1'b0;
      end else if (ce) begin
         if (prbs_err) begin
            prbs_tog <= ~prbs_tog;
         end
      end
   end

   // Half period for the selected blink rate
   // Default branch unreachable; falls back to the reset rate
   always @* begin
      case (rate)
         2'b00: half_len = HALF0[CW-1:0];
         2'b01: half_len = HALF1[CW-1:0];
         2'b10: half_len = HALF2[CW-1:0];
         2'b11: half_len = HALF3[CW-1:0];
         default: half_len = HALF2[CW-1:0];
      endcase
   end

   // Next count, kept apart so the wrap test and the increment agree
   assign blink_next = blink_cnt + cnt_one;

   // Free-running blink generator; a rate change takes effect at once
   // Compare with >= so a shorter new period never overruns the counter
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blink_cnt <= {CW{1'b0}};
         blink_phase <= 1'b0;
      end else if (ce) begin
         if (blink_next >= half_len) begin
            blink_cnt <= {CW{1'b0}};
            blink_phase <= ~blink_phase;
         end else begin
            blink_cnt <= blink_next;
         end
      end
   end

   // Stretchers hold an event for one full blink period so a short burst stays visible
   // Bypass passes events through one register, never combinationally
   assign stretch_ev = {mii_tx_err | mii_rx_err, rx_act, tx_act, tx_act | rx_act};
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_str
         aic_stretch #(.CW(CW)) u_str (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .ev(stretch_ev[g]),
            .bypass(bypass),
            .len({half_len[CW-2:0], 1'b0}),
            .q(stretch_q[g])
         );
      end
   endgenerate
   assign act_any_s = stretch_q[0];
   assign act_tx_s = stretch_q[1];
   assign act_rx_s = stretch_q[2];
   assign err_s = stretch_q[3];

   // Link-up terms that blink while their activity is stretched high
   // Steady on with no activity, so a quiet link still shows as up
   assign trx_blink = link_up & (act_any_s ? blink_phase : 1'b1);
   assign tx_blink = link_up & (act_tx_s ? blink_phase : 1'b1);
   assign rx_blink = link_up & (act_rx_s ? blink_phase : 1'b1);

   // Per-indicator source selection, same code table for all three
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_led
         wire [3:0] src;
         reg v;
         assign src = src_all[4*g+3:4*g];
         always @* begin
            case (src)
               `AIC_SRC_LINK: v = link_up;
               `AIC_SRC_LINK_TRX: v = trx_blink;
               `AIC_SRC_LINK_TX: v = tx_blink;
               `AIC_SRC_LINK_RX: v = rx_blink;
               `AIC_SRC_MASTER: v = link_up & master_role;
               `AIC_SRC_SLAVE: v = link_up & ~master_role;
               `AIC_SRC_ACT: v = act_any_s;
               `AIC_SRC_LOST: v = link_lost;
               `AIC_SRC_PRBS: v = prbs_tog;
               `AIC_SRC_MIIERR: v = err_s;
               default: v = 1'b0;
            endcase
         end
         assign led_val[g] = v;
      end
   endgenerate

   // Outputs registered so the pins never glitch on a source change
   // A reserved code shows dark, never the previous source
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         led_0 <= 1'b0;
         led_1 <= 1'b0;
         led_2 <= 1'b0;
      end else if (ce) begin
         led_0 <= led_val[0];
         led_1 <= led_val[1];
         led_2 <= led_val[2];
      end
   end
endmodule // aic_top

`default_nettype wire

// ---- aic_top_properties.sv ----
// Checker for the indicator block, bound to aic_top.
// Assumes whole-word bus writes; checks pause while ce is low.
`timescale 1ns/1ns
`default_nettype none
module aic_top_checker (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Reset
   input wire logic ce, // Clock enable
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer
   input wire logic hwrite, // Write
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   input wire logic hreadyout, // Slave ready
   input wire logic hresp, // Response
   input wire logic link_up, // Link
   input wire logic master_role, // Role
   input wire logic tx_act, // Tx activity
   input wire logic rx_act, // Rx activity
   input wire logic mii_rx_err, // Rx error
   input wire logic led_0, // Indicator 0
   input wire logic led_1, // Indicator 1
   input wire logic led_2 // Indicator 2
);
   logic pend;
   logic [15:0] cfg;
   wire rsv2 = cfg[11:8] inside {4'h7, 4'h8} || cfg[11:8] > 4'hb;
   // Shadow config word, lands at the data-phase edge like the design's
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 1'b0;
         cfg <= 16'h2610;
      end else if (ce) begin
         pend <= hsel && htrans[1] && hready && hwrite && haddr == 32'h1140;
         if (pend) begin
            cfg <= hwdata[15:0] & 16'h7fff;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);
   chk_resp_okay: assert property (hresp == 1'b0) else $error("error response");
   chk_ready_high: assert property (hreadyout) else $error("wait state inserted");
   chk_link_steady: assert property ((cfg[3:0] == 4'h0 && link_up)[*3] |-> led_0)
      else $error("link indicator dark");
   chk_link_dark: assert property ((cfg[3:0] == 4'h0 && !link_up)[*3] |-> !led_0)
      else $error("link indicator lit");
   chk_master_lit: assert property ((cfg[3:0] == 4'h4 && link_up && master_role)[*3] |-> led_0)
      else $error("master indicator dark");
   chk_slave_lit: assert property ((cfg[7:4] == 4'h5 && link_up && !master_role)[*3] |-> led_1)
      else $error("slave indicator dark");
   chk_reserved_off: assert property (rsv2[*3] |-> !led_2)
      else $error("reserved code lit");
   chk_act_pulse: assert property ((cfg[11:8] == 4'h6 && tx_act) ##1 (cfg[11:8] == 4'h6)[*2] |-> led_2)
      else $error("activity missed");
   chk_bypass_idle: assert property ((cfg[11:8] == 4'h6 && cfg[14] && !tx_act && !rx_act)[*4] |-> !led_2)
      else $error("stretch not bypassed");
   chk_err_pulse: assert property ((cfg[7:4] == 4'hb && mii_rx_err) ##1 (cfg[7:4] == 4'hb)[*2] |-> led_1)
      else $error("error missed");
   cover property (cfg[3:0] == 4'h9 && led_0);
   cover property (cfg[14] && led_2);
   cover property (cfg[3:0] == 4'ha && $changed(led_0));
endmodule // aic_top_checker
bind aic_top aic_top_checker i_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .link_up(link_up),
   .master_role(master_role), .tx_act(tx_act), .rx_act(rx_act), .mii_rx_err(mii_rx_err), .led_0(led_0),
   .led_1(led_1), .led_2(led_2));
`default_nettype wire

// ---- aic_lamp.sv ----
// Board lamp model: logs toggle spacing and turn-on count.
// Assumes an active-high lamp drive synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module aic_lamp (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Reset
   input wire logic led, // Lamp drive
   output logic [15:0] gap, // Cycles between toggles
   output logic [7:0] rises // Turn-on count
);
   logic prev;
   logic [15:0] cnt;
   // Gap counts edges, so a blink half period reads back directly
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
         cnt <= 16'h0;
         gap <= 16'h0;
         rises <= 8'h0;
      end else begin
         prev <= led;
         cnt <= cnt + 16'h1;
         if (led !== prev) begin
            gap <= cnt + 16'h1;
            cnt <= 16'h0;
            rises <= rises + {7'h0, led};
         end
      end
   end
endmodule // aic_lamp
`default_nettype wire

// ---- tb.sv ----
// Testbench for aic_top: bus tasks, lamp models, scripted checks.
// Assumes short blink half periods passed as parameters.
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int hc [4] = '{4, 8, 16, 40};
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, link_up = 1'b0, master_role = 1'b0;
   logic tx_act = 1'b0, rx_act = 1'b0, prbs_err = 1'b0, mii_tx_err = 1'b0, mii_rx_err = 1'b0, ce = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hready, hresp, led_0, led_1, led_2;
   logic [15:0] gap0, gap1, gap2;
   logic [7:0] rise0, rise1, rise2, r2;
   int miscompares = 0, compares = 0, cycles = 0;
   aic_top #(.HALF0(24'h4), .HALF1(24'h8), .HALF2(24'h10), .HALF3(24'h28)) i_aic_top (.clk(clk), .rst_n(rst_n),
      .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link_up(link_up),
      .master_role(master_role), .tx_act(tx_act), .rx_act(rx_act), .prbs_err(prbs_err), .mii_tx_err(mii_tx_err),
      .mii_rx_err(mii_rx_err), .led_0(led_0), .led_1(led_1), .led_2(led_2));
   aic_lamp i_lamp_0 (.clk(clk), .rst_n(rst_n), .led(led_0), .gap(gap0), .rises(rise0));
   aic_lamp i_lamp_1 (.clk(clk), .rst_n(rst_n), .led(led_1), .gap(gap1), .rises(rise1));
   aic_lamp i_lamp_2 (.clk(clk), .rst_n(rst_n), .led(led_2), .gap(gap2), .rises(rise2));
   initial begin
      forever #50 clk = ~clk;
   end
   // Hang guard well above the scripted run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         stop_test;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single-word transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One-cycle events: {prbs_err, tx_act, mii_rx_err}
   task automatic pulse(input logic [2:0] m);
      {prbs_err, tx_act, mii_rx_err} <= m;
      @(posedge clk);
      {prbs_err, tx_act, mii_rx_err} <= 3'h0;
      @(posedge clk);
   endtask
   task automatic stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      tick(4);
      rst_n <= 1'b1;
      tick(1);
      bus(1'b0, 32'h1140, 32'h0); chk(rd, 32'h2610);
      bus(1'b0, 32'h2000, 32'h0); chk(rd, 32'h0);
      bus(1'b1, 32'h1140, 32'hffff); bus(1'b0, 32'h1140, 32'h0); chk(rd, 32'h7fff);
      link_up <= 1'b1;
      master_role <= 1'b1;
      bus(1'b1, 32'h1140, 32'h0754); tick(4); chk({led_2, led_1, led_0}, 32'h1);
      master_role <= 1'b0;
      for (int k = 7; k < 16; k++) begin
         if (k < 9 || k > 11) begin
            bus(1'b1, 32'h1140, {20'h0, k[3:0], 8'h54}); tick(4); chk({led_2, led_1, led_0}, 32'h2);
         end
      end
      bus(1'b1, 32'h1140, 32'h0009);
      link_up <= 1'b0;
      tick(12); chk({led_1, led_0}, 32'h1);
      bus(1'b0, 32'h0004, 32'h0); chk(rd, 32'h2);
      tick(4); chk(led_0, 32'h0);
      link_up <= 1'b1;
      tick(4); chk({led_1, led_0}, 32'h2);
      bus(1'b1, 32'h1140, 32'h000a);
      pulse(3'h4); tick(4); chk(led_0, 32'h1);
      pulse(3'h4); tick(4); chk(led_0, 32'h0);
      // Clock enable low: an error pulse must not toggle the indicator
      ce <= 1'b0;
      pulse(3'h4);
      ce <= 1'b1;
      tick(4); chk(led_0, 32'h0);
      bus(1'b1, 32'h1140, 32'h36b0);
      pulse(3'h3); tick(40); chk({led_2, led_1}, 32'h3);
      tick(60); chk({led_2, led_1}, 32'h0);
      bus(1'b1, 32'h1140, 32'h76b0);
      r2 = rise2;
      pulse(3'h3); tick(4); chk({led_2, led_1}, 32'h0);
      chk(rise2, r2 + 8'h1);
      tx_act <= 1'b1;
      // Held activity makes codes 1 and 2 blink at the selected rate
      for (int r = 0; r < 4; r++) begin
         bus(1'b1, 32'h1140, {18'h0, r[1:0], 12'h321});
         tick(6 * hc[r]);
         chk(gap0, hc[r]);
         chk(gap1, hc[r]);
         chk(led_2, 32'h1);
      end
      // Receive activity, with transmit still held, blinks code 3 at the last selected rate
      rx_act <= 1'b1;
      tick(6 * hc[3]); chk(gap2, hc[3]);
      // Interface transmit error with bypass: on while high, off at once
      bus(1'b1, 32'h1140, 32'h4bb0);
      mii_tx_err <= 1'b1;
      tick(4); chk({led_2, led_1}, 32'h3);
      mii_tx_err <= 1'b0;
      tick(4); chk({led_2, led_1}, 32'h0);
      stop_test;
   end
endmodule // tb
`default_nettype wire
